/* verilog/servo_address_compare_gating.sv */
// Servo address compare registers, masked comparators and gate pin override
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
//
// Operation
// - Set track mask bits make the track comparator ignore those positions.
// - Track capture holds decoded track address, feeds comparator, readable by software.
// - Software write to track capture accepted only while track shift enable low.
// - Index target supplies sixteen-bit target to the index comparator.
// - Set index mask bits make the index comparator treat positions as don't-care.
// - Index capture holds decoded index address, feeds comparator, readable.
// - Software write to index capture accepted only while index shift enable low.
// - Gate config bits 15..8 grant pin control to value bits 7..0.
// - Each value bit drives its pin only while its enable bit is set.
// - Select A software enable overrides drive-fault control of select A.
// - Masks and gate config reset to zero: all match, no pin overridden.
// - Compare valid only when both masked comparisons hold.
// - Sixteen-bit read/write track target feeds the track comparator.
module servo_address_compare_gating
  import servo_cmp_pkg::*;
(
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  input  wire logic                           clk_en,
  // Register port
  input  wire servo_cmp_pkg::reg_req_t        reg_req,
  output logic [servo_cmp_pkg::DATA_W-1:0]    reg_rdata,
  // Burst sequencer
  input  wire servo_cmp_pkg::seq_in_t         seq_in,
  // Normal pin drive from sequencer and fault logic
  input  wire servo_cmp_pkg::gate_pins_t      seq_pins,
  input  wire logic                           fault_sel_a_en,
  input  wire logic                           fault_sel_a_val,
  // Pins and status
  output servo_cmp_pkg::gate_pins_t           gate_pins,
  output logic                                addr_match
);
  import servo_cmp_pkg::*;

  logic [DATA_W-1:0] track_target_q;
  logic [DATA_W-1:0] track_mask_q;
  logic [DATA_W-1:0] track_capture_q;
  logic [DATA_W-1:0] gate_config_q;
  logic [DATA_W-1:0] index_target_q;
  logic [DATA_W-1:0] index_mask_q;
  logic [DATA_W-1:0] index_capture_q;
  logic [DATA_W-1:0] rdata_d;
  logic              track_match;
  logic              index_match;
  logic [PIN_N-1:0]  pin_en;
  logic [PIN_N-1:0]  pin_val;
  logic [PIN_N-1:0]  base_pins;
  logic [PIN_N-1:0]  pins_d;
  logic [PIN_N-1:0]  pins_q;
  logic              wr_track_target;
  logic              wr_track_mask;
  logic              wr_track_capture;
  logic              wr_gate_config;
  logic              wr_index_target;
  logic              wr_index_mask;
  logic              wr_index_capture;

  // Write decode
  always_comb
  begin
    wr_track_target  = 1'b0;
    wr_track_mask    = 1'b0;
    wr_track_capture = 1'b0;
    wr_gate_config   = 1'b0;
    wr_index_target  = 1'b0;
    wr_index_mask    = 1'b0;
    wr_index_capture = 1'b0;
    if (reg_req.wr)
    begin
      if (reg_req.addr == REG_TRACK_TARGET)
        wr_track_target = 1'b1;
      else if (reg_req.addr == REG_TRACK_MASK)
        wr_track_mask = 1'b1;
      else if (reg_req.addr == REG_TRACK_CAPTURE)
        wr_track_capture = 1'b1;
      else if (reg_req.addr == REG_GATE_CONFIG)
        wr_gate_config = 1'b1;
      else if (reg_req.addr == REG_INDEX_TARGET)
        wr_index_target = 1'b1;
      else if (reg_req.addr == REG_INDEX_MASK)
        wr_index_mask = 1'b1;
      else if (reg_req.addr == REG_INDEX_CAPTURE)
        wr_index_capture = 1'b1;
    end
  end

  // Targets: no documented reset, cleared for determinism
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      track_target_q <= VALUE_RST;
      index_target_q <= VALUE_RST;
    end
    else if (clk_en)
    begin
      if (wr_track_target)
        track_target_q <= reg_req.wdata;
      if (wr_index_target)
        index_target_q <= reg_req.wdata;
    end
  end

  // Masks
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      track_mask_q <= MASK_RST;
      index_mask_q <= MASK_RST;
    end
    else if (clk_en)
    begin
      if (wr_track_mask)
        track_mask_q <= reg_req.wdata;
      if (wr_index_mask)
        index_mask_q <= reg_req.wdata;
    end
  end

  // Track capture: sequencer load wins, software only while shift is idle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      track_capture_q <= VALUE_RST;
    else if (clk_en)
    begin
      if (seq_in.track_load)
        track_capture_q <= seq_in.track_code;
      else if (wr_track_capture && !seq_in.track_shift_en)
        track_capture_q <= reg_req.wdata;
    end
  end

  // Index capture, same policy
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      index_capture_q <= VALUE_RST;
    else if (clk_en)
    begin
      if (seq_in.index_load)
        index_capture_q <= seq_in.index_code;
      else if (wr_index_capture && !seq_in.index_shift_en)
        index_capture_q <= reg_req.wdata;
    end
  end

  // Gate override config
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      gate_config_q <= GATE_RST;
    else if (clk_en && wr_gate_config)
      gate_config_q <= reg_req.wdata;
  end

  // Comparators
  masked_compare u_track_cmp (
    .capture (track_capture_q),
    .target  (track_target_q),
    .mask    (track_mask_q),
    .match   (track_match)
  );

  masked_compare u_index_cmp (
    .capture (index_capture_q),
    .target  (index_target_q),
    .mask    (index_mask_q),
    .match   (index_match)
  );

  // Combinational so status follows the registers with no extra lag
  assign addr_match = track_match & index_match;

  // Pin override
  assign pin_en  = gate_config_q[GATE_EN_LSB +: PIN_N];
  assign pin_val = gate_config_q[GATE_VAL_LSB +: PIN_N];

  always_comb
  begin
    base_pins = seq_pins;
    // Fault drive applies only below the software override
    if (fault_sel_a_en)
      base_pins[PIN_SELECT_A] = fault_sel_a_val;
    pins_d = (pin_en & pin_val) | (~pin_en & base_pins);
  end

  // Registered pins keep outputs glitch-free; costs one cycle of latency
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pins_q <= {PIN_N{1'b0}};
    else if (clk_en)
      pins_q <= pins_d;
  end

  assign gate_pins = pins_q;

  // Read mux
  always_comb
  begin
    rdata_d = READ_ZERO;
    if (reg_req.addr == REG_TRACK_TARGET)
      rdata_d = track_target_q;
    else if (reg_req.addr == REG_TRACK_MASK)
      rdata_d = track_mask_q;
    else if (reg_req.addr == REG_TRACK_CAPTURE)
      rdata_d = track_capture_q;
    else if (reg_req.addr == REG_GATE_CONFIG)
      rdata_d = gate_config_q;
    else if (reg_req.addr == REG_INDEX_TARGET)
      rdata_d = index_target_q;
    else if (reg_req.addr == REG_INDEX_MASK)
      rdata_d = index_mask_q;
    else if (reg_req.addr == REG_INDEX_CAPTURE)
      rdata_d = index_capture_q;
    else if (reg_req.addr == REG_COMPARE_STAT)
      rdata_d[STAT_MATCH_BIT] = addr_match;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata <= READ_ZERO;
    else if (clk_en)
    begin
      if (reg_req.rd)
        reg_rdata <= rdata_d;
      else
        reg_rdata <= READ_ZERO;
    end
  end

endmodule : servo_address_compare_gating

/* shared/servo_cmp_pkg.sv */
// Package: register map, field layout and carriers for the servo address compare block
package servo_cmp_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PIN_N  = 8;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] REG_TRACK_TARGET  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_TRACK_MASK    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_TRACK_CAPTURE = 4'h2;
  localparam logic [ADDR_W-1:0] REG_GATE_CONFIG   = 4'h3;
  localparam logic [ADDR_W-1:0] REG_INDEX_TARGET  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_INDEX_MASK    = 4'h5;
  localparam logic [ADDR_W-1:0] REG_INDEX_CAPTURE = 4'h6;
  localparam logic [ADDR_W-1:0] REG_COMPARE_STAT  = 4'h7;

  // Reset values
  localparam logic [DATA_W-1:0] MASK_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] GATE_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] VALUE_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] READ_ZERO  = 16'h0000;

  // Gate config field layout
  localparam int unsigned GATE_VAL_LSB = 0;
  localparam int unsigned GATE_EN_LSB  = 8;
  // Pin order within the 8-bit groups
  localparam int unsigned PIN_SELECT_A = 2;
  // Status word field
  localparam int unsigned STAT_MATCH_BIT = 0;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  // Sequencer loads of the decoded codes
  typedef struct packed {
    logic              track_shift_en;
    logic              track_load;
    logic [DATA_W-1:0] track_code;
    logic              index_shift_en;
    logic              index_load;
    logic [DATA_W-1:0] index_code;
  } seq_in_t;

  // Gate and select pin group
  typedef struct packed {
    logic gate_a;
    logic gate_b;
    logic gate_c;
    logic gate_d;
    logic discharge;
    logic select_a;
    logic extra_sel2;
    logic extra_sel1;
  } gate_pins_t;

endpackage : servo_cmp_pkg

/* verilog/masked_compare.sv */
// Masked equality comparator: set mask bits are don't-care
`timescale 1ns/1ps
module masked_compare
  import servo_cmp_pkg::*;
(
  // Operands
  input  wire logic [DATA_W-1:0] capture,
  input  wire logic [DATA_W-1:0] target,
  input  wire logic [DATA_W-1:0] mask,
  // Result
  output logic                   match
);
  import servo_cmp_pkg::*;

  assign match = &((capture ~^ target) | mask);

endmodule : masked_compare

/* sim/servo_cmp_props.sv */
// Checker: register shadow, compare status and pin drive properties
`timescale 1ns/1ps
module servo_cmp_props
  import servo_cmp_pkg::*;
(
  // Clock and control
  input wire logic                        clk_sys,
  input wire logic                        rst,
  input wire logic                        clk_en,
  // Ports of the block
  input wire servo_cmp_pkg::reg_req_t     reg_req,
  input wire logic [DATA_W-1:0]           reg_rdata,
  input wire servo_cmp_pkg::seq_in_t      seq_in,
  input wire servo_cmp_pkg::gate_pins_t   seq_pins,
  input wire logic                        fault_sel_a_en,
  input wire logic                        fault_sel_a_val,
  input wire servo_cmp_pkg::gate_pins_t   gate_pins,
  input wire logic                        addr_match
);
  logic [DATA_W-1:0] sh_q [8];
  logic [DATA_W-1:0] rd_exp;
  logic [7:0]        en;
  logic [7:0]        base;
  logic [7:0]        pin_exp;
  logic              m_exp;
  // Later loads win over a same-cycle software write
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      sh_q <= '{default: '0};
    else if (clk_en)
    begin
      if (reg_req.wr && reg_req.addr < 4'h7 && !(reg_req.addr == 4'h2 && seq_in.track_shift_en)
          && !(reg_req.addr == 4'h6 && seq_in.index_shift_en))
        sh_q[reg_req.addr[2:0]] <= reg_req.wdata;
      if (seq_in.track_load)
        sh_q[2] <= seq_in.track_code;
      if (seq_in.index_load)
        sh_q[6] <= seq_in.index_code;
    end
  always_comb
  begin
    m_exp = ((sh_q[2] ^ sh_q[0]) & ~sh_q[1]) == '0 && ((sh_q[6] ^ sh_q[4]) & ~sh_q[5]) == '0;
    rd_exp = reg_req.addr[3] ? '0 : sh_q[reg_req.addr[2:0]];
    if (reg_req.addr == 4'h7)
      rd_exp = {15'h0, m_exp};
    en = sh_q[3][15:8];
    base = seq_pins;
    if (fault_sel_a_en)
      base[PIN_SELECT_A] = fault_sel_a_val;
    pin_exp = (en & sh_q[3][7:0]) | (~en & base);
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_match_both: assert property (addr_match == m_exp)
    else $error("compare status differs from masked compare");
  // Edge that releases reset still runs the reset branch, so no attempt starts there
  a_read_value: assert property (!rst && clk_en && reg_req.rd |=> reg_rdata == $past(rd_exp))
    else $error("read data wrong");
  a_rdata_idle: assert property (!rst && clk_en && !reg_req.rd |=> reg_rdata == '0)
    else $error("read data outside answer cycle");
  a_pins_drive: assert property (!rst && clk_en |=> gate_pins == $past(pin_exp))
    else $error("pin drive wrong");
  a_select_prio: assert property (!rst && clk_en && en[2]
    |=> gate_pins.select_a == $past(sh_q[3][2]))
    else $error("select A not under software control");
  a_no_override: assert property (!rst && clk_en && en == '0 |=> gate_pins == $past(base))
    else $error("pins overridden with no enable");
  a_pins_freeze: assert property (!rst && !clk_en |=> $stable(gate_pins))
    else $error("pins moved while frozen");
  a_rdata_freeze: assert property (!rst && !clk_en |=> $stable(reg_rdata))
    else $error("read data moved while frozen");
endmodule : servo_cmp_props

/* sim/servo_seq_model.sv */
// Burst sequencer model: decoded code loads and shift enables
`timescale 1ns/1ps
module servo_seq_model
  import servo_cmp_pkg::*;
(
  input wire logic                clk_sys,
  output servo_cmp_pkg::seq_in_t  seq_in
);
  initial seq_in = '0;
  task automatic shift(input logic trk, input logic idx);
    @(posedge clk_sys);
    seq_in.track_shift_en <= trk;
    seq_in.index_shift_en <= idx;
  endtask : shift
  // Code bus turns over after the load so a stale value never looks valid
  task automatic load(input logic trk, input logic [DATA_W-1:0] code);
    @(posedge clk_sys);
    seq_in.track_load <= trk;
    seq_in.index_load <= !trk;
    seq_in.track_code <= code;
    seq_in.index_code <= code;
    @(posedge clk_sys);
    seq_in.track_load <= 1'b0;
    seq_in.index_load <= 1'b0;
    seq_in.track_code <= ~code;
    seq_in.index_code <= ~code;
  endtask : load
endmodule : servo_seq_model

/* sim/tb_servo_address_compare_gating.sv */
// Testbench: register access, compare and pin override sequences
`timescale 1ns/1ps
module tb_servo_address_compare_gating;
  import servo_cmp_pkg::*;
  logic clk_sys, rst, clk_en, f_en, f_val, addr_match;
  logic [DATA_W-1:0] reg_rdata;
  reg_req_t req;
  seq_in_t seq_in;
  gate_pins_t seq_pins, gate_pins;
  int err_total = 0;
  int n_tests = 0;
  servo_seq_model i_servo_seq_model (.clk_sys(clk_sys), .seq_in(seq_in));
  servo_address_compare_gating i_servo_address_compare_gating (.clk_sys(clk_sys), .rst(rst),
    .clk_en(clk_en), .reg_req(req), .reg_rdata(reg_rdata), .seq_in(seq_in),
    .seq_pins(seq_pins), .fault_sel_a_en(f_en), .fault_sel_a_val(f_val),
    .gate_pins(gate_pins), .addr_match(addr_match));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic cfg(input logic [15:0] c, input logic [15:0] e);
    wr(REG_GATE_CONFIG, c);
    @(posedge clk_sys);
    #1 chk(gate_pins, e);
  endtask : cfg
  initial
  begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    conclude();
  end
  initial
  begin
    rst = 1; clk_en = 1; req = '0; seq_pins = '0; f_en = 0; f_val = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 0;
    for (int a = 0; a < 10; a++)
      rd(a[3:0], a == 7 ? 16'h0001 : 16'h0000);
    wr(REG_TRACK_TARGET, 16'h1235);
    #1 chk(addr_match, 16'h0000);
    i_servo_seq_model.load(1, 16'h1234);
    #1 chk(addr_match, 16'h0000);
    wr(REG_TRACK_MASK, 16'h0001);
    #1 chk(addr_match, 16'h0001);
    rd(REG_TRACK_CAPTURE, 16'h1234);
    wr(REG_INDEX_TARGET, 16'h80A5);
    #1 chk(addr_match, 16'h0000);
    i_servo_seq_model.load(0, 16'h80A4);
    wr(REG_INDEX_MASK, 16'h0001);
    #1 chk(addr_match, 16'h0001);
    rd(REG_COMPARE_STAT, 16'h0001);
    rd(REG_INDEX_CAPTURE, 16'h80A4);
    i_servo_seq_model.shift(1, 1);
    wr(REG_TRACK_CAPTURE, 16'h0F0F);
    wr(REG_INDEX_CAPTURE, 16'h0F0F);
    rd(REG_TRACK_CAPTURE, 16'h1234);
    rd(REG_INDEX_CAPTURE, 16'h80A4);
    i_servo_seq_model.shift(0, 0);
    wr(REG_TRACK_CAPTURE, 16'h0F0F);
    rd(REG_TRACK_CAPTURE, 16'h0F0F);
    wr(REG_INDEX_CAPTURE, 16'h0F0F);
    rd(REG_INDEX_CAPTURE, 16'h0F0F);
    wr(REG_COMPARE_STAT, 16'hFFFF);
    rd(REG_COMPARE_STAT, 16'h0000);
    for (int n = 0; n < 8; n++)
      cfg(16'h00FF | (16'h0100 << n), 16'h0001 << n);
    @(posedge clk_sys);
    seq_pins <= 8'h5A; f_en <= 1; f_val <= 1;
    cfg(16'h0000, 16'h005E);
    cfg(16'h0400, 16'h005A);
    cfg(16'hF00F, 16'h000E);
    // Frozen clock enable must hold the pins
    @(posedge clk_sys);
    clk_en <= 0; seq_pins <= 8'h00;
    repeat (3) @(posedge clk_sys);
    #1 chk(gate_pins, 16'h000E);
    @(posedge clk_sys);
    clk_en <= 1;
    repeat (2) @(posedge clk_sys);
    #1 chk(gate_pins, 16'h0004);
    @(posedge clk_sys);
    rst <= 1;
    @(posedge clk_sys);
    rst <= 0;
    rd(REG_GATE_CONFIG, 16'h0000);
    rd(REG_INDEX_MASK, 16'h0000);
    conclude();
  end
endmodule : tb_servo_address_compare_gating
bind servo_address_compare_gating servo_cmp_props i_servo_cmp_props (.clk_sys(clk_sys),
  .rst(rst), .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata), .seq_in(seq_in),
  .seq_pins(seq_pins), .fault_sel_a_en(fault_sel_a_en), .fault_sel_a_val(fault_sel_a_val),
  .gate_pins(gate_pins), .addr_match(addr_match));
